// *** shared/mlp_pkg.sv ***
// constants, field layout and decode tables for the motor loop/power profile bank
package mlp_pkg;

  // ****************************************************************
  // register addresses and reset values
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] SPEED_LOOP_CONFIG_ADDR = 8'h8E;
  localparam logic [7:0] POWER_REGULATION_CONFIG_ADDR = 8'h90;
  localparam logic [7:0] TWO_PHASE_DUTY_PROFILE_ADDR = 8'h96;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

  // ****************************************************************
  // field positions, one layout for each of the three registers
  // ****************************************************************
  localparam int unsigned PARITY_BIT = 31;
  // speed loop configuration
  localparam int unsigned KP_MSB = 29;
  localparam int unsigned KP_LSB = 20;
  localparam int unsigned KI_MSB = 19;
  localparam int unsigned KI_LSB = 8;
  localparam int unsigned VMAX_MSB = 7;
  localparam int unsigned VMAX_LSB = 5;
  localparam int unsigned VMIN_MSB = 4;
  localparam int unsigned VMIN_LSB = 2;
  localparam int unsigned LMODE_MSB = 1;
  localparam int unsigned LMODE_LSB = 0;
  // power regulation configuration
  localparam int unsigned MSPD_MSB = 30;
  localparam int unsigned MSPD_LSB = 15;
  localparam int unsigned DTC_BIT = 14;
  localparam int unsigned MPWR_MSB = 13;
  localparam int unsigned MPWR_LSB = 4;
  localparam int unsigned HYST_MSB = 3;
  localparam int unsigned HYST_LSB = 2;
  localparam int unsigned PMODE_MSB = 1;
  localparam int unsigned PMODE_LSB = 0;
  // two phase profile: step k at STEP0_MSB - 3k down to STEP0_LSB - 3k
  localparam int unsigned STEP_COUNT = 7;
  localparam int unsigned STEP_W = 3;
  localparam int unsigned STEP0_MSB = 30;
  localparam int unsigned STEP0_LSB = 28;

  // scale divisors of the raw fields (documentation for the consumer)
  localparam int unsigned KP_DIVISOR = 10000;
  localparam int unsigned KI_DIVISOR = 1000000;
  localparam int unsigned MAX_SPEED_DIVISOR = 16;
  localparam int unsigned MAX_POWER_DIVISOR = 4;

  // ****************************************************************
  // mode encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    MLP_LOOP_OFF = 2'b00,
    MLP_LOOP_SPEED = 2'b01,
    MLP_LOOP_POWER = 2'b10,
    MLP_LOOP_RSVD = 2'b11
  } mlp_loop_mode_t;

  typedef enum logic [1:0] {
    MLP_PWR_OFF = 2'b00,
    MLP_PWR_CLOSED = 2'b01,
    MLP_PWR_LIMIT = 2'b10,
    MLP_PWR_RSVD = 2'b11
  } mlp_pwr_mode_t;

  // ****************************************************************
  // decode tables, tenths of a percent and hundredths of a percent
  // ****************************************************************
  localparam int unsigned PCT10_W = 10;
  localparam int unsigned PCT100_W = 14;
  typedef logic [PCT10_W-1:0] mlp_pct10_t;
  typedef logic [PCT100_W-1:0] mlp_pct100_t;

  localparam mlp_pct10_t UPPER_TBL [8] = '{10'h3E8, 10'h3B6, 10'h384, 10'h352,
                                          10'h320, 10'h2EE, 10'h2BC, 10'h28A};
  localparam mlp_pct10_t LOWER_TBL [8] = '{10'h000, 10'h019, 10'h032, 10'h04B,
                                          10'h064, 10'h096, 10'h0C8, 10'h0FA};
  localparam mlp_pct10_t HYST_TBL [4] = '{10'h032, 10'h04B, 10'h064, 10'h07D};
  // 0, 50, 75, 83.75, 87.5, 93.75, 97.5, 99 percent
  localparam mlp_pct100_t DUTY_TBL [8] = '{14'h0000, 14'h1388, 14'h1D4C, 14'h20B7,
                                          14'h222E, 14'h249F, 14'h2616, 14'h26AC};

endpackage

// *** core/mlp_duty_decode.sv ***
// one two-phase step duty code to its duty in hundredths of a percent
`timescale 1ns/1ps
module mlp_duty_decode (
  input wire logic [2:0] step_code, // three-bit step duty code
  output mlp_pkg::mlp_pct100_t step_duty // duty, hundredths of a percent
);

  // table lookup, code 0 is off, code 7 is 99 percent
  always_comb
  begin
    step_duty = mlp_pkg::DUTY_TBL[step_code];
  end

endmodule

// *** core/mlp_cfg_bank.sv ***
// register bank holding loop gains, power limits and the two-phase duty profile
//
// Function
// - Ten-bit proportional gain in bits 29..20 of the speed loop register, value/10000.
// - Twelve-bit integral gain in bits 19..8, effective value/1000000.
// - Upper clamp code in bits 7..5 maps 100 down to 65 percent.
// - Lower clamp code in bits 4..2 maps 0 up to 25 percent.
// - Loop select bits 1..0: off, speed, power; code 3 reserved.
// - Sixteen-bit speed ceiling in bits 30..15, hertz is value/16.
// - Bit 14 of power register enables dead-time compensation.
// - Ten-bit power ceiling in bits 13..4, watts is value/4.
// - Hysteresis code in bits 3..2 maps to 5, 7.5, 10, 12.5 percent.
// - Power mode bits 1..0: off, closed loop, limit; code 3 reserved.
// - Seven three-bit step duty codes from bits 30..28 down to 12..10.
// - Power register at 0x90 and its neighbours reset to all zeros.
`timescale 1ns/1ps
module mlp_cfg_bank (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic cfg_wr_en, // write strobe, one cycle
  input wire logic cfg_rd_en, // read strobe, one cycle
  input wire logic [7:0] cfg_addr, // register byte address
  input wire logic [31:0] cfg_wdata, // write data
  output logic [31:0] cfg_rdata, // read data, valid with cfg_rd_valid
  output logic cfg_rd_valid, // read answer pulse
  output logic cfg_addr_err, // pulse: access hit no register
  output logic [9:0] loop_prop_gain, // proportional gain raw
  output logic [11:0] loop_integral_gain, // integral gain raw
  output logic [2:0] loop_upper_clamp, // upper clamp code
  output logic [2:0] loop_lower_clamp, // lower clamp code
  output mlp_pkg::mlp_pct10_t loop_upper_pct10, // upper clamp, tenths of percent
  output mlp_pkg::mlp_pct10_t loop_lower_pct10, // lower clamp, tenths of percent
  output mlp_pkg::mlp_loop_mode_t loop_mode, // closed loop selection
  output logic loop_speed_on, // speed regulation selected
  output logic loop_power_on, // power regulation selected
  output logic [15:0] max_speed, // speed ceiling raw, hertz*16
  output logic deadband_correction_on, // dead-time compensation enable
  output logic [9:0] max_power, // power ceiling raw, watts*4
  output logic [1:0] power_reg_hysteresis, // hysteresis code
  output mlp_pkg::mlp_pct10_t power_hyst_pct10, // hysteresis, tenths of percent
  output mlp_pkg::mlp_pwr_mode_t power_mode, // input power regulation mode
  output logic power_closed_on, // closed loop power control selected
  output logic power_limit_on, // power limit control selected
  output logic [20:0] duty_step_codes, // step k codes at [3k+2:3k]
  output logic [97:0] duty_step_pct100 // step k duty at [14k+13:14k]
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [31:0] spd_q;
  logic [31:0] spd_d;
  logic [31:0] pwr_q;
  logic [31:0] pwr_d;
  logic [31:0] prof_q;
  logic [31:0] prof_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic addr_err_q;
  logic addr_err_d;
  logic hit_spd;
  logic hit_pwr;
  logic hit_prof;

  // address decode
  always_comb
  begin
    hit_spd = 1'b0;
    hit_pwr = 1'b0;
    hit_prof = 1'b0;
    if (cfg_addr == mlp_pkg::SPEED_LOOP_CONFIG_ADDR)
    begin
      hit_spd = 1'b1;
    end
    else if (cfg_addr == mlp_pkg::POWER_REGULATION_CONFIG_ADDR)
    begin
      hit_pwr = 1'b1;
    end
    else if (cfg_addr == mlp_pkg::TWO_PHASE_DUTY_PROFILE_ADDR)
    begin
      hit_prof = 1'b1;
    end
  end

  // next register values: whole word written, parity and reserved bits kept as written
  always_comb
  begin
    spd_d = spd_q;
    pwr_d = pwr_q;
    prof_d = prof_q;
    rdata_d = rdata_q;
    rd_valid_d = cfg_rd_en;
    addr_err_d = (cfg_wr_en | cfg_rd_en) & ~(hit_spd | hit_pwr | hit_prof);
    if (cfg_wr_en)
    begin
      if (hit_spd)
      begin
        spd_d = cfg_wdata;
      end
      else if (hit_pwr)
      begin
        pwr_d = cfg_wdata;
      end
      else if (hit_prof)
      begin
        prof_d = cfg_wdata;
      end
    end
    // read returns stored word, old value if written in the same cycle
    if (cfg_rd_en)
    begin
      if (hit_spd)
      begin
        rdata_d = spd_q;
      end
      else if (hit_pwr)
      begin
        rdata_d = pwr_q;
      end
      else if (hit_prof)
      begin
        rdata_d = prof_q;
      end
      else
      begin
        rdata_d = mlp_pkg::READ_UNMAPPED;
      end
    end
  end

  // register update
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spd_q <= mlp_pkg::REG_RESET;
      pwr_q <= mlp_pkg::REG_RESET;
      prof_q <= mlp_pkg::REG_RESET;
      rdata_q <= mlp_pkg::REG_RESET;
      rd_valid_q <= 1'b0;
      addr_err_q <= 1'b0;
    end
    else
    begin
      spd_q <= spd_d;
      pwr_q <= pwr_d;
      prof_q <= prof_d;
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
      addr_err_q <= addr_err_d;
    end
  end

  // ****************************************************************
  // decoded views, registered in step with the raw fields
  // ****************************************************************
  mlp_pkg::mlp_pct10_t upper_d;
  mlp_pkg::mlp_pct10_t upper_q;
  mlp_pkg::mlp_pct10_t lower_d;
  mlp_pkg::mlp_pct10_t lower_q;
  mlp_pkg::mlp_pct10_t hyst_d;
  mlp_pkg::mlp_pct10_t hyst_q;
  logic [3:0] flags_d;
  logic [3:0] flags_q;
  logic [97:0] duty_d;
  logic [97:0] duty_q;

  // one duty decoder per profile step, fed from the next register value
  genvar k;
  generate
    for (k = 0; k < mlp_pkg::STEP_COUNT; k++)
    begin : g_step
      mlp_duty_decode u_dec (
        .step_code (prof_d[mlp_pkg::STEP0_MSB - mlp_pkg::STEP_W*k -: mlp_pkg::STEP_W]),
        .step_duty (duty_d[mlp_pkg::PCT100_W*k +: mlp_pkg::PCT100_W])
      );
    end
  endgenerate

  // clamp, hysteresis and mode decode
  always_comb
  begin
    upper_d = mlp_pkg::UPPER_TBL[spd_d[mlp_pkg::VMAX_MSB:mlp_pkg::VMAX_LSB]];
    lower_d = mlp_pkg::LOWER_TBL[spd_d[mlp_pkg::VMIN_MSB:mlp_pkg::VMIN_LSB]];
    hyst_d = mlp_pkg::HYST_TBL[pwr_d[mlp_pkg::HYST_MSB:mlp_pkg::HYST_LSB]];
    flags_d = 4'h0;
    // reserved codes select nothing
    case (mlp_pkg::mlp_loop_mode_t'(spd_d[mlp_pkg::LMODE_MSB:mlp_pkg::LMODE_LSB]))
      mlp_pkg::MLP_LOOP_SPEED: flags_d[0] = 1'b1;
      mlp_pkg::MLP_LOOP_POWER: flags_d[1] = 1'b1;
      default: flags_d[1:0] = 2'b00;
    endcase
    case (mlp_pkg::mlp_pwr_mode_t'(pwr_d[mlp_pkg::PMODE_MSB:mlp_pkg::PMODE_LSB]))
      mlp_pkg::MLP_PWR_CLOSED: flags_d[2] = 1'b1;
      mlp_pkg::MLP_PWR_LIMIT: flags_d[3] = 1'b1;
      default: flags_d[3:2] = 2'b00;
    endcase
  end

  // decoded view registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upper_q <= mlp_pkg::UPPER_TBL[0];
      lower_q <= mlp_pkg::LOWER_TBL[0];
      hyst_q <= mlp_pkg::HYST_TBL[0];
      flags_q <= 4'h0;
      duty_q <= '0;
    end
    else
    begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      hyst_q <= hyst_d;
      flags_q <= flags_d;
      duty_q <= duty_d;
    end
  end

  // ****************************************************************
  // outputs, all slices of flip-flops
  // ****************************************************************
  assign cfg_rdata = rdata_q;
  assign cfg_rd_valid = rd_valid_q;
  assign cfg_addr_err = addr_err_q;
  assign loop_prop_gain = spd_q[mlp_pkg::KP_MSB:mlp_pkg::KP_LSB];
  assign loop_integral_gain = spd_q[mlp_pkg::KI_MSB:mlp_pkg::KI_LSB];
  assign loop_upper_clamp = spd_q[mlp_pkg::VMAX_MSB:mlp_pkg::VMAX_LSB];
  assign loop_lower_clamp = spd_q[mlp_pkg::VMIN_MSB:mlp_pkg::VMIN_LSB];
  assign loop_upper_pct10 = upper_q;
  assign loop_lower_pct10 = lower_q;
  assign loop_mode = mlp_pkg::mlp_loop_mode_t'(spd_q[mlp_pkg::LMODE_MSB:mlp_pkg::LMODE_LSB]);
  assign loop_speed_on = flags_q[0];
  assign loop_power_on = flags_q[1];
  assign max_speed = pwr_q[mlp_pkg::MSPD_MSB:mlp_pkg::MSPD_LSB];
  assign deadband_correction_on = pwr_q[mlp_pkg::DTC_BIT];
  assign max_power = pwr_q[mlp_pkg::MPWR_MSB:mlp_pkg::MPWR_LSB];
  assign power_reg_hysteresis = pwr_q[mlp_pkg::HYST_MSB:mlp_pkg::HYST_LSB];
  assign power_hyst_pct10 = hyst_q;
  assign power_mode = mlp_pkg::mlp_pwr_mode_t'(pwr_q[mlp_pkg::PMODE_MSB:mlp_pkg::PMODE_LSB]);
  assign power_closed_on = flags_q[2];
  assign power_limit_on = flags_q[3];
  assign duty_step_pct100 = duty_q;

  // step codes repacked, step 0 in the low bits
  generate
    for (k = 0; k < mlp_pkg::STEP_COUNT; k++)
    begin : g_code
      assign duty_step_codes[mlp_pkg::STEP_W*k +: mlp_pkg::STEP_W] =
        prof_q[mlp_pkg::STEP0_MSB - mlp_pkg::STEP_W*k -: mlp_pkg::STEP_W];
    end
  endgenerate

endmodule

// *** verification/mlp_cfg_bank_properties.sv ***
// checker of the loop/power profile bank, bound to its ports
`timescale 1ns/1ps
module mlp_cfg_bank_checker (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic cfg_wr_en, // write
  input wire logic cfg_rd_en, // read
  input wire logic [7:0] cfg_addr, // address
  input wire logic [31:0] cfg_wdata, // wdata
  input wire logic [31:0] cfg_rdata, // rdata
  input wire logic cfg_rd_valid, // answer
  input wire logic cfg_addr_err, // miss
  input wire logic [9:0] loop_prop_gain, // kp
  input wire mlp_pkg::mlp_loop_mode_t loop_mode, // loop select
  input wire logic loop_speed_on, // speed on
  input wire logic [15:0] max_speed, // speed cap
  input wire logic [9:0] max_power, // power cap
  input wire logic [20:0] duty_step_codes // steps
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // properties
  // ****************
  sequence s_rd_ans;
    cfg_rd_valid && cfg_rdata[30:15] == $past(max_speed);
  endsequence
  property p_kp;
    cfg_wr_en && cfg_addr == 8'h8E |=> loop_prop_gain == $past(cfg_wdata[29:20]);
  endproperty
  a_kp: assert property (p_kp) else $error("kp not loaded");
  property p_mode;
    loop_speed_on == (loop_mode == mlp_pkg::MLP_LOOP_SPEED);
  endproperty
  a_mode: assert property (p_mode) else $error("speed flag off mode");
  property p_spd;
    cfg_wr_en && cfg_addr == 8'h90 |=> max_speed == $past(cfg_wdata[30:15]);
  endproperty
  a_spd: assert property (p_spd) else $error("speed cap not loaded");
  property p_pwr;
    cfg_wr_en && cfg_addr == 8'h90 |=> max_power == $past(cfg_wdata[13:4]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power cap not loaded");
  property p_step;
    cfg_wr_en && cfg_addr == 8'h96 |=> duty_step_codes[20:18] == $past(cfg_wdata[12:10]);
  endproperty
  a_step: assert property (p_step) else $error("step six not loaded");
  property p_rst;
    $rose(rst_n) |-> max_speed == 16'h0 && loop_prop_gain == 10'h0 && !cfg_rd_valid;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_rd;
    cfg_rd_en && cfg_addr == 8'h90 |=> s_rd_ans;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_err;
    (cfg_wr_en || cfg_rd_en) && !(cfg_addr inside {8'h8E, 8'h90, 8'h96}) |=> cfg_addr_err;
  endproperty
  a_err: assert property (p_err) else $error("miss not flagged");
endmodule
bind mlp_cfg_bank mlp_cfg_bank_checker u_chk (.core_clk, .rst_n, .cfg_wr_en,
  .cfg_rd_en, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .cfg_addr_err,
  .loop_prop_gain, .loop_mode, .loop_speed_on, .max_speed, .max_power, .duty_step_codes);

// *** verification/mlp_cfg_bank_tb_top.sv ***
// self-checking bench of the loop/power profile bank
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 128'(e), 128'(g))
module mlp_cfg_bank_tb_top;
  logic core_clk, rst_n, cfg_wr_en, cfg_rd_en, cfg_rd_valid, cfg_addr_err;
  logic loop_speed_on, loop_power_on, deadband_correction_on, power_closed_on, power_limit_on;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rd_q;
  logic [9:0] loop_prop_gain, max_power;
  logic [11:0] loop_integral_gain;
  logic [2:0] loop_upper_clamp, loop_lower_clamp, c;
  logic [1:0] power_reg_hysteresis;
  logic [15:0] max_speed;
  logic [20:0] duty_step_codes;
  logic [97:0] duty_step_pct100;
  mlp_pkg::mlp_pct10_t loop_upper_pct10, loop_lower_pct10, power_hyst_pct10;
  mlp_pkg::mlp_loop_mode_t loop_mode;
  mlp_pkg::mlp_pwr_mode_t power_mode;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] w [3];
  logic [7:0] adr [3] = '{8'h8E, 8'h90, 8'h96};
  typedef struct packed {
    logic [2:0] code;
    logic [9:0] up;
    logic [9:0] lo;
    logic [13:0] du;
  } mlp_row_t;
  // code, upper clamp, lower clamp (tenths), duty (hundredths)
  mlp_row_t rows [8] = '{'{3'h0, 10'h3E8, 10'h000, 14'h0000}, '{3'h1, 10'h3B6, 10'h019, 14'h1388},
    '{3'h2, 10'h384, 10'h032, 14'h1D4C}, '{3'h3, 10'h352, 10'h04B, 14'h20B7},
    '{3'h4, 10'h320, 10'h064, 14'h222E}, '{3'h5, 10'h2EE, 10'h096, 14'h249F},
    '{3'h6, 10'h2BC, 10'h0C8, 14'h2616}, '{3'h7, 10'h28A, 10'h0FA, 14'h26AC}};
  mlp_cfg_bank dut (.core_clk, .rst_n, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .cfg_rd_valid, .cfg_addr_err, .loop_prop_gain, .loop_integral_gain,
    .loop_upper_clamp, .loop_lower_clamp, .loop_upper_pct10, .loop_lower_pct10, .loop_mode,
    .loop_speed_on, .loop_power_on, .max_speed, .deadband_correction_on, .max_power,
    .power_reg_hysteresis, .power_hyst_pct10, .power_mode, .power_closed_on,
    .power_limit_on, .duty_step_codes, .duty_step_pct100);
  // ****************
  // helpers
  // ****************
  task automatic chk(string n, logic [127:0] e, logic [127:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // one write strobe, then an idle cycle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr_en = 1'b0;
    @(negedge core_clk);
  endtask
  // one read strobe, answer due one cycle later
  task automatic rd(logic [7:0] a);
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(negedge core_clk);
    `CHK("rd_valid", 1'b1, cfg_rd_valid);
    rd_q = cfg_rdata;
    cfg_rd_en = 1'b0;
    @(negedge core_clk);
    `CHK("rd_valid_end", 1'b0, cfg_rd_valid);
  endtask
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // free-running 10 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0;
    repeat (2) @(negedge core_clk);
    `CHK("upper_rst", 10'h3E8, loop_upper_pct10);
    `CHK("hyst_rst", 10'h032, power_hyst_pct10);
    rst_n = 1'b1;
    foreach (adr[i])
    begin
      rd(adr[i]);
      `CHK("reg_rst", 32'h0, rd_q);
    end
    foreach (rows[k])
    begin
      c = rows[k].code;
      w[0] = {1'b1, 1'b0, c, 7'h55, c, 9'h1A5, c, c, c[1:0]};
      w[1] = {c[0], c, 13'h1ABC, c[0], c, 7'h33, c[1:0], c[1:0]};
      w[2] = {1'b1, {7{c}}, 10'h2C5};
      foreach (w[i])
        wr(adr[i], w[i]);
      `CHK("kp", {c, 7'h55}, loop_prop_gain);
      `CHK("ki", {c, 9'h1A5}, loop_integral_gain);
      `CHK("upper", c, loop_upper_clamp);
      `CHK("upper_pct", rows[k].up, loop_upper_pct10);
      `CHK("lower", c, loop_lower_clamp);
      `CHK("lower_pct", rows[k].lo, loop_lower_pct10);
      `CHK("loop_mode", c[1:0], loop_mode);
      `CHK("speed_on", c[1:0] == 2'h1, loop_speed_on);
      `CHK("power_on", c[1:0] == 2'h2, loop_power_on);
      `CHK("max_speed", {c, 13'h1ABC}, max_speed);
      `CHK("dtc", c[0], deadband_correction_on);
      `CHK("max_power", {c, 7'h33}, max_power);
      `CHK("hyst", c[1:0], power_reg_hysteresis);
      // hysteresis steps sit 5 percent above the lower clamp steps
      `CHK("hyst_pct", rows[c[1:0]].lo + 10'h032, power_hyst_pct10);
      `CHK("pwr_mode", c[1:0], power_mode);
      `CHK("closed_on", c[1:0] == 2'h1, power_closed_on);
      `CHK("limit_on", c[1:0] == 2'h2, power_limit_on);
      `CHK("steps", {7{c}}, duty_step_codes);
      `CHK("duty", {7{rows[k].du}}, duty_step_pct100);
      foreach (w[i])
      begin
        rd(adr[i]);
        `CHK("readback", w[i], rd_q);
      end
    end
    // unmapped read flags a miss and returns zero; unmapped write changes nothing
    cfg_rd_en = 1'b1;
    cfg_addr = 8'h92;
    @(negedge core_clk);
    `CHK("addr_err", 1'b1, cfg_addr_err);
    `CHK("unmapped", 32'h0, cfg_rdata);
    cfg_rd_en = 1'b0;
    wr(8'h94, 32'hFFFFFFFF);
    rd(8'h90);
    `CHK("untouched", w[1], rd_q);
    // read and write together return the old word, then a back-to-back write
    cfg_wr_en = 1'b1;
    cfg_rd_en = 1'b1;
    cfg_wdata = 32'h80004001;
    @(negedge core_clk);
    `CHK("old_read", w[1], cfg_rdata);
    `CHK("dtc_on", 1'b1, deadband_correction_on);
    cfg_rd_en = 1'b0;
    cfg_wdata = 32'h7FFF8000;
    @(negedge core_clk);
    cfg_wr_en = 1'b0;
    `CHK("spd_full", 16'hFFFF, max_speed);
    `CHK("dtc_off", 1'b0, deadband_correction_on);
    // reset in mid-run clears the registers; the upper clamp view returns to 100 percent
    rst_n = 1'b0;
    @(negedge core_clk);
    `CHK("spd_rst", 16'h0, max_speed);
    `CHK("upper_rst2", 10'h3E8, loop_upper_pct10);
    rst_n = 1'b1;
    rd(8'h96);
    `CHK("prof_rst", 32'h0, rd_q);
    complete_run();
  end
endmodule
